// file: dv/bwc_slow_device.sv
// Slow external device model that drives the active-low wait request pin
`timescale 1ns/1ps
module bwc_slow_device
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    // Access seen by the device
    input  wire logic        start_i,
    input  wire logic        select_i,
    input  wire logic [3:0]  hold_i,
    // Wait request pin, pulled up when released
    output logic             wait_req_n_o
);
    logic [3:0] age_reg;
    logic [3:0] age_next;

    assign age_next = start_i ? 4'h1 :
                      (select_i && age_reg != 4'hF) ? age_reg + 4'h1 : age_reg;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            age_reg <= 4'h0;
        else
            age_reg <= age_next;

    // Low like a chip select, only within its own access
    assign wait_req_n_o = start_i ? (hold_i == 4'h0) : !(select_i && age_reg < hold_i);
endmodule // bwc_slow_device

// file: dv/test_external_bus_wait_state_control.sv
// Self-checking testbench of the external bus wait-state controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_external_bus_wait_state_control;
    import bwc_pkg::*;
    logic        clk, rst_n, stby, wr, rd, start, busy, wins, cend, pin;
    logic        pce, ems, eas, fre, p0;
    logic [15:0] addr;
    logic [7:0]  wd, rdata, v, rv;
    logic [3:0]  hold;
    int          bad_count, cmp_count, w, k, seed;

    bwc_bus_delay_controller dut (.sys_clk_i(clk), .arst_n_i(rst_n), .hw_standby_i(stby),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .ext_cycle_start_i(start), .bus_busy_o(busy),
        .wait_insert_o(wins), .cycle_end_o(cend), .wait_req_n_i(pin),
        .periph_clk_en_o(pce), .emu_memory_select_o(ems), .emu_area_select_o(eas),
        .flash_regs_enable_o(fre));
    bwc_slow_device dev (.sys_clk_i(clk), .arst_n_i(rst_n), .start_i(start),
        .select_i(busy), .hold_i(hold), .wait_req_n_o(pin));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int exp_w(int m, int c, int h);
        if (m == 1)
            return 0;
        if (m == 3 && h == 0)
            return 0;
        return c;
    endfunction

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask

    // Runs one external cycle, counting waits and cycles from the start cycle to the end pulse;
    // with midwr it writes the register and pulses start again in the first wait state
    task automatic run_cycle(input logic [3:0] h, input bit midwr, output int nw, output int nk);
        @(posedge clk);
        hold <= h;
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        nw = 0;
        nk = 0;
        for (int i = 0; i < 40 && nk == 0; i++)
        begin
            @(posedge clk);
            wr <= midwr && i == 1;
            start <= midwr && i == 1;
            addr <= CTRL_ADDR;
            wd <= 8'h00;
            #1;
            if (wins === 1'h1)
                nw++;
            if (cend === 1'h1)
                nk = i + 2;
        end
        if (nk == 0)
        begin
            bad_count++;
            end_sim();
        end
    endtask

    initial
    begin
        seed = 58737;
        {rst_n, stby, wr, rd, start} = 5'h00;
        addr = 16'h0000;
        wd = 8'h00;
        hold = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(CTRL_ADDR, rv);
        `CHK(rv, CTRL_RESET)
        `CHK({ems, eas, fre, pce}, 4'h1)
        $display("reset values done");
        for (int i = 0; i < 6; i++)
        begin
            v = 8'(xs());
            wr_reg(CTRL_ADDR, v);
            #1 p0 = pce;
            `CHK({ems, eas, fre}, {v[7], v[6], v[4]})
            @(posedge clk);
            #1 `CHK(pce, v[5] ? ~p0 : 1'h1)
            wr_reg(16'hFFC3, ~v);
            rd_reg(CTRL_ADDR, rv);
            `CHK(rv, v)
            rd_reg(16'hFFC3, rv);
            `CHK(rv, RDATA_UNMAPPED)
        end
        @(posedge clk);
        stby <= 1'h1;
        wr <= 1'h1;
        addr <= CTRL_ADDR;
        wd <= 8'hF3;
        @(posedge clk);
        stby <= 1'h0;
        wr <= 1'h0;
        rd_reg(CTRL_ADDR, rv);
        `CHK(rv, CTRL_RESET)
        $display("register access done");
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 4; c++)
                for (int h = 0; h < 2; h++)
                begin
                    v = 8'(xs());
                    wr_reg(CTRL_ADDR, {v[7:4], 2'(m), 2'(c)});
                    run_cycle(h ? 4'hF : 4'h0, 1'b0, w, k);
                    `CHK(k, w + 3)
                    if (m == 2 && h == 1)
                        `CHK(w > 3 && w < 19, 1'h1)
                    else
                        `CHK(w, exp_w(m, c, h))
                end
        $display("wait modes done");
        wr_reg(CTRL_ADDR, 8'h03);
        run_cycle(4'hF, 1'b1, w, k);
        `CHK(w, 3)
        run_cycle(4'hF, 1'b0, w, k);
        `CHK(w, 0)
        $display("mid-cycle write done");
        end_sim();
    end
endmodule // test_external_bus_wait_state_control

// file: rtl/bwc_bus_delay_controller.sv
// External bus wait-state controller with its control register and peripheral clock enable
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - Register loads 08 on reset, standby
// - Bits 3:2 pick one of four modes
// - Bits 1:0 give zero to three waits
// - Programmable mode: exact count, pin ignored
// - Pin mode: low in last wait adds one
// - Pin mode: extend while pin stays low
// - Auto mode: sample pin in T2 only
// - Auto mode: never beyond configured count
// - Bit 5 halves the peripheral clock
// - Bit 4 plain read/write, reset zero
// - Bits 7:6 stored only, reset zero
module bwc_bus_delay_controller
    import bwc_pkg::*;
#(
    parameter int unsigned  SYNC_STAGES = 2
)
(
    // Clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               arst_n_i,
    // Hardware standby entry, same clock domain
    input  wire logic               hw_standby_i,
    // Register port
    input  wire logic [ADDR_W-1:0]  reg_addr_i,
    input  wire logic [DATA_W-1:0]  reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [DATA_W-1:0]  reg_rdata_o,
    // Processor external bus cycle
    input  wire logic               ext_cycle_start_i,
    output logic                    bus_busy_o,
    output logic                    wait_insert_o,
    output logic                    cycle_end_o,
    // External wait request pin
    input  wire logic               wait_req_n_i,
    // Peripheral clock enable and stored side fields
    output logic                    periph_clk_en_o,
    output logic                    emu_memory_select_o,
    output logic                    emu_area_select_o,
    output logic                    flash_regs_enable_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [DATA_W-1:0]       ctrl_reg;
    logic [DATA_W-1:0]       ctrl_next;
    logic [DATA_W-1:0]       rdata_reg;
    logic [DATA_W-1:0]       rdata_next;
    logic [SYNC_STAGES-1:0]  wait_sync_reg;
    logic                    wait_low;
    bwc_state_t              state_reg;
    bwc_state_t              state_next;
    logic [1:0]              mode_lat_reg;
    logic [1:0]              mode_lat_next;
    logic [1:0]              count_lat_reg;
    logic [1:0]              count_lat_next;
    logic [1:0]              cnt_reg;
    logic [1:0]              cnt_next;
    logic                    pclk_en_reg;
    logic                    pclk_en_next;
    logic                    busy_reg;
    logic                    wait_ins_reg;
    logic                    end_reg;

    // ****************************************
    // Register decode
    // ****************************************
    wire logic        addr_hit    = (reg_addr_i == CTRL_ADDR);
    wire logic        ctrl_write  = reg_wr_i & addr_hit;
    wire logic        ctrl_read   = reg_rd_i & addr_hit;
    wire logic [1:0]  cfg_mode    = ctrl_reg[DELAY_MODE_HI_POS:DELAY_MODE_LO_POS];
    wire logic [1:0]  cfg_count   = ctrl_reg[DELAY_COUNT_HI_POS:DELAY_COUNT_LO_POS];
    wire logic        cfg_halve   = ctrl_reg[PERIPH_HALVE_POS];

    // Standby reload wins over a write in the same cycle
    assign ctrl_next  = hw_standby_i ? CTRL_RESET :
                        ctrl_write   ? reg_wdata_i : ctrl_reg;
    assign rdata_next = ctrl_read ? ctrl_reg : RDATA_UNMAPPED;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_reg  <= CTRL_RESET;
            rdata_reg <= RDATA_UNMAPPED;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // Wait pin synchroniser
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wait_sync_reg <= '1;
        else
            wait_sync_reg <= {wait_sync_reg[SYNC_STAGES-2:0], wait_req_n_i};
    end

    assign wait_low = ~wait_sync_reg[SYNC_STAGES-1];

    // ****************************************
    // Bus-cycle state machine
    // ****************************************
    // Decides the step after T2 from the latched mode, count and pin level
    function automatic bwc_state_t after_t2(input logic [1:0] mode,
                                            input logic [1:0] count,
                                            input logic       pin_low);
        bwc_state_t s;
        s = BWC_T3;
        case (mode)
            MODE_PROG:     s = (count != COUNT_ZERO) ? BWC_TW : BWC_T3;
            MODE_PIN:      s = ((count != COUNT_ZERO) || pin_low) ? BWC_TW : BWC_T3;
            MODE_PIN_AUTO: s = ((count != COUNT_ZERO) && pin_low) ? BWC_TW : BWC_T3;
            default:       s = BWC_T3;
        endcase
        return s;
    endfunction

    always_comb
    begin
        state_next     = state_reg;
        mode_lat_next  = mode_lat_reg;
        count_lat_next = count_lat_reg;
        cnt_next       = cnt_reg;
        case (state_reg)
            BWC_IDLE:
            begin
                if (ext_cycle_start_i)
                begin
                    state_next     = BWC_T1;
                    mode_lat_next  = cfg_mode;
                    count_lat_next = cfg_count;
                end
            end
            BWC_T1:
                state_next = BWC_T2;
            BWC_T2:
            begin
                state_next = after_t2(mode_lat_reg, count_lat_reg, wait_low);
                cnt_next   = (count_lat_reg == COUNT_ZERO) ? COUNT_ONE : count_lat_reg;
            end
            BWC_TW:
            begin
                if (cnt_reg != COUNT_ONE)
                    cnt_next = cnt_reg - COUNT_ONE;
                else if ((mode_lat_reg == MODE_PIN) && wait_low)
                    cnt_next = COUNT_ONE;
                else
                    state_next = BWC_T3;
            end
            BWC_T3:
                state_next = BWC_IDLE;
            default:
                state_next = BWC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg     <= BWC_IDLE;
            mode_lat_reg  <= MODE_PIN;
            count_lat_reg <= COUNT_ZERO;
            cnt_reg       <= COUNT_ZERO;
            busy_reg      <= 1'b0;
            wait_ins_reg  <= 1'b0;
            end_reg       <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            mode_lat_reg  <= mode_lat_next;
            count_lat_reg <= count_lat_next;
            cnt_reg       <= cnt_next;
            busy_reg      <= (state_next != BWC_IDLE);
            wait_ins_reg  <= (state_next == BWC_TW);
            end_reg       <= (state_next == BWC_T3);
        end
    end

    // ****************************************
    // Peripheral clock enable
    // ****************************************
    // Every cycle when undivided, every other cycle when halved
    assign pclk_en_next = cfg_halve ? ~pclk_en_reg : 1'b1;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pclk_en_reg <= 1'b1;
        else
            pclk_en_reg <= pclk_en_next;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_o         = rdata_reg;
    assign bus_busy_o          = busy_reg;
    assign wait_insert_o       = wait_ins_reg;
    assign cycle_end_o         = end_reg;
    assign periph_clk_en_o     = pclk_en_reg;
    assign emu_memory_select_o = ctrl_reg[EMU_MEMORY_SEL_POS];
    assign emu_area_select_o   = ctrl_reg[EMU_AREA_SEL_POS];
    assign flash_regs_enable_o = ctrl_reg[FLASH_REGS_EN_POS];

    // ****************************************
    // Assertions
    // ****************************************
    a_standby_reload: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        hw_standby_i |=> (ctrl_reg == CTRL_RESET))
        else $error("control register not reloaded on standby");

    a_none_mode_nowait: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_NONE) |=> (state_reg == BWC_T3))
        else $error("wait inserted in no-wait mode");

    a_prog_exact_count: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_PROG) && (count_lat_reg == 2'h3)
        |=> (state_reg == BWC_TW) [*3] ##1 (state_reg == BWC_T3))
        else $error("programmable mode wait count wrong");

    a_pin_extend_low: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_TW) && (cnt_reg == COUNT_ONE) && (mode_lat_reg == MODE_PIN) && wait_low
        |=> (state_reg == BWC_TW) && wait_insert_o)
        else $error("pin mode did not extend on low pin");

    a_pin_release_high: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_TW) && (cnt_reg == COUNT_ONE) && (mode_lat_reg == MODE_PIN) && !wait_low
        |=> (state_reg == BWC_T3) ##0 cycle_end_o)
        else $error("pin mode did not end after pin high");

    a_auto_pin_high: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_PIN_AUTO) && !wait_low
        |=> (state_reg == BWC_T3))
        else $error("auto mode waited with pin high");

    a_auto_bounded: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_PIN_AUTO) && wait_low
        && (count_lat_reg == 2'h2) |=> (state_reg == BWC_TW) [*2] ##1 (state_reg == BWC_T3))
        else $error("auto mode exceeded count");

    a_periph_halve: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        cfg_halve && $past(cfg_halve) |-> (periph_clk_en_o != $past(periph_clk_en_o)))
        else $error("peripheral enable not halved");

    a_read_back: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ctrl_read |=> (reg_rdata_o == $past(ctrl_reg)))
        else $error("register read data wrong");

    a_latch_stable: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg != BWC_IDLE) && (state_next != BWC_IDLE) && (state_reg != BWC_IDLE)
        && (state_next != BWC_T1) |=> $stable(mode_lat_reg) && $stable(count_lat_reg))
        else $error("latched mode changed mid cycle");

    c_pin_extra_wait: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_TW) && (mode_lat_reg == MODE_PIN) ##1 (state_reg == BWC_TW) [*3]);

    c_auto_wait: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_PIN_AUTO) ##1 (state_reg == BWC_TW));

    c_write_mid_cycle: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ctrl_write && (state_reg == BWC_TW));

    c_standby_reload: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        hw_standby_i && (ctrl_reg != CTRL_RESET));

    c_periph_halved: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        cfg_halve ##1 cfg_halve);

    a_latch_capture: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_IDLE) && ext_cycle_start_i
        |=> (mode_lat_reg == $past(cfg_mode)) && (count_lat_reg == $past(cfg_count)))
        else $error("mode or count not latched at cycle start");

    a_start_ignored: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg != BWC_IDLE) && ext_cycle_start_i
        |=> (state_reg != BWC_T1))
        else $error("start accepted during a running cycle");

    a_periph_full: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !$past(cfg_halve) |-> periph_clk_en_o)
        else $error("peripheral enable low while undivided");

    a_write_lands: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ctrl_write && !hw_standby_i |=> (ctrl_reg == $past(reg_wdata_i)))
        else $error("register write not stored");

    a_prog_count_one: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T2) && (mode_lat_reg == MODE_PROG) && (count_lat_reg == COUNT_ONE)
        |=> (state_reg == BWC_TW) ##1 (state_reg == BWC_T3))
        else $error("single wait count wrong");

    a_auto_no_extend: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_TW) && (mode_lat_reg == MODE_PIN_AUTO) && (cnt_reg == COUNT_ONE)
        |=> (state_reg == BWC_T3))
        else $error("auto mode extended past last wait");

    // ****************************************
    // Wait-state tally
    // ****************************************
    // Wait states counted over the current bus cycle
    logic [3:0]              tw_seen_reg;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tw_seen_reg <= 4'h0;
        else if (state_reg == BWC_T1)
            tw_seen_reg <= 4'h0;
        else if ((state_reg == BWC_TW) && (tw_seen_reg != 4'hF))
            tw_seen_reg <= tw_seen_reg + 4'h1;
    end

    a_prog_total: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T3) && (mode_lat_reg == MODE_PROG)
        |-> (tw_seen_reg == {2'h0, count_lat_reg}))
        else $error("programmable mode total waits wrong");

    a_none_total: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T3) && (mode_lat_reg == MODE_NONE)
        |-> (tw_seen_reg == 4'h0))
        else $error("no-wait mode inserted waits");

    a_auto_total: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T3) && (mode_lat_reg == MODE_PIN_AUTO)
        |-> (tw_seen_reg == {2'h0, count_lat_reg}) || (tw_seen_reg == 4'h0))
        else $error("auto mode total waits wrong");

    a_pin_total: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_reg == BWC_T3) && (mode_lat_reg == MODE_PIN)
        |-> (tw_seen_reg >= {2'h0, count_lat_reg}))
        else $error("pin mode fewer waits than count");

endmodule // bwc_bus_delay_controller

// file: rtl/bwc_pkg.sv
// Package with register map, field layout and bus-cycle states of the wait controller
package bwc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned  ADDR_W           = 16;
    localparam int unsigned  DATA_W           = 8;
    localparam logic [15:0]  CTRL_ADDR        = 16'hFFC2;
    localparam logic [7:0]   CTRL_RESET       = 8'h08;
    localparam logic [7:0]   RDATA_UNMAPPED   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned  EMU_MEMORY_SEL_POS  = 7;
    localparam int unsigned  EMU_AREA_SEL_POS    = 6;
    localparam int unsigned  PERIPH_HALVE_POS    = 5;
    localparam int unsigned  FLASH_REGS_EN_POS   = 4;
    localparam int unsigned  DELAY_MODE_HI_POS   = 3;
    localparam int unsigned  DELAY_MODE_LO_POS   = 2;
    localparam int unsigned  DELAY_COUNT_HI_POS  = 1;
    localparam int unsigned  DELAY_COUNT_LO_POS  = 0;

    // ****************************************
    // Wait modes and counts
    // ****************************************
    localparam logic [1:0]   MODE_PROG        = 2'h0;
    localparam logic [1:0]   MODE_NONE        = 2'h1;
    localparam logic [1:0]   MODE_PIN         = 2'h2;
    localparam logic [1:0]   MODE_PIN_AUTO    = 2'h3;
    localparam logic [1:0]   COUNT_ZERO       = 2'h0;
    localparam logic [1:0]   COUNT_ONE        = 2'h1;

    // ****************************************
    // Bus-cycle states
    // ****************************************
    typedef enum logic [2:0] {
        BWC_IDLE,
        BWC_T1,
        BWC_T2,
        BWC_TW,
        BWC_T3
    } bwc_state_t;

endpackage
